// ### verilog/pcl_pkg.sv
// Package: constants for the port pin configuration logic
package pcl_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] PCL_ADDR_L_DATA = 8'hd0;  // Four-pin port data
    localparam logic [7:0] PCL_ADDR_L_CFG  = 8'hd1;  // Four-pin port configuration
    localparam logic [7:0] PCL_ADDR_L_PIN  = 8'hd2;  // Four-pin port pin levels
    localparam logic [7:0] PCL_ADDR_G_DATA = 8'hd4;  // Eight-bit port data
    localparam logic [7:0] PCL_ADDR_G_CFG  = 8'hd5;  // Eight-bit port configuration
    localparam logic [7:0] PCL_ADDR_G_PIN  = 8'hd6;  // Eight-bit port pin levels
    localparam logic [7:0] PCL_ADDR_I_PIN  = 8'hd7;  // Analog port pin levels
    localparam logic [7:0] PCL_ADDR_D_DATA = 8'hdc;  // Output-only port data
    localparam logic [7:0] PCL_ADDR_CNTRL  = 8'hee;  // Control, serial pin select
    // Field positions
    localparam int PCL_G_FAULT_BIT  = 1;  // Fault output pin
    localparam int PCL_G_SIN_BIT    = 6;  // Serial data in, input only
    localparam int PCL_G_OSC_BIT    = 7;  // Oscillator pin
    localparam int PCL_CNTRL_SEL    = 3;  // Serial pin select bit
    // Reset values
    localparam logic [7:0] PCL_RST_PORT = 8'h00;  // Bidirectional registers
    localparam logic [3:0] PCL_RST_D    = 4'hf;   // Output-only port preset high
    localparam logic [7:0] PCL_RST_CNTRL = 8'h00; // Control register
    localparam logic [3:0] PCL_L_LOW_ONES = 4'hf; // Lower pin bits read as ones
endpackage : pcl_pkg

// ### verilog/pcl_port.sv
// Port pin configuration logic: bidirectional, analog and output ports
`timescale 1ns/1ps

// What this block does
// RULE_01: Config and data pick hi-z, pull-up, drive
// RULE_02: Four-pin and eight-bit ports have config, data, pin addresses
// RULE_03: Four-pin port low pin bits read ones
// RULE_04: Upper four-pin bits feed wakeup and interrupt; code feeds them to multi_input_wakeup only
// RULE_05: Eight-bit data bits 6,7 read zero
// RULE_06: Data bit 7 write one enters deep-stop
// RULE_07: Data bit 6 write one enters light-sleep
// RULE_08: Config bit 6 selects alternate shift phase
// RULE_09: Config bit 7 with RC enables restart delay
// RULE_10: RC option: pin 7 input, rise wakes
// RULE_11: Crystal option: pin 7 drives oscillator out
// RULE_12: Pin 1 is dedicated fault output
// RULE_13: Eight-bit port alternate functions routed
// RULE_14: Analog port is input-only hi-z
// RULE_15: Output-only port high during reset
// RULE_16: Reset clears port registers to hi-z
// RULE_17: Serial select routes pins 5,4 to serial
// RULE_18: Pin inputs pass two synchroniser stages
module pcl_port
    import pcl_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Option straps and peripheral sources
    input  wire logic       rc_osc_option,
    input  wire logic       osc_clock,
    input  wire logic       fault_n,
    input  wire logic       shift_clock_out,
    input  wire logic       serial_data_out,
    input  wire logic       timer_io_out,
    input  wire logic       timer_io_oe,
    // Four-pin port pins (upper nibble)
    input  wire logic [3:0] l_pin_in,
    output logic      [3:0] l_pin_out,
    output logic      [3:0] l_pin_oe,
    output logic      [3:0] l_pull_en,
    // Eight-bit port pins
    input  wire logic [7:0] g_pin_in,
    output logic      [7:0] g_pin_out,
    output logic      [7:0] g_pin_oe,
    output logic      [7:0] g_pull_en,
    // Analog port, input only
    input  wire logic [7:0] i_pin_in,
    // Output-only port
    output logic      [3:0] d_pin_out,
    // Alternate function inputs to peripherals
    output logic      [3:0] multi_input_wakeup,
    output logic            ext_irq_in,
    output logic            timer_capture_pin,
    output logic            timer_io_in,
    output logic            serial_data_in,
    output logic            shift_clock_in,
    // Mode controls
    output logic            deep_stop_req,
    output logic            light_sleep_req,
    output logic            shift_alt_phase,
    output logic            restart_delay_enable,
    output logic            rc_wake
);

    // Software registers
    logic [7:0] l_data_q;   // Four-pin data (low nibble is flags)
    logic [7:0] l_cfg_q;    // Four-pin configuration
    logic [7:0] g_data_q;   // Eight-bit port data
    logic [7:0] g_cfg_q;    // Eight-bit port configuration
    logic [3:0] d_data_q;   // Output-only port data
    logic [7:0] cntrl_q;    // Control register
    // Synchronisers
    logic [3:0] l_s1_q, l_s2_q;
    logic [7:0] g_s1_q, g_s2_q;
    logic [7:0] i_s1_q, i_s2_q;
    logic       g7_prev_q;  // Pin 7 history for edge detect
    logic       rc_q;       // Oscillator option caught after reset
    logic       fault_s1_q, fault_s2_q;
    logic [7:0] rdata_d;

    // Decode of one register write
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : wr_hit

    // Register writes, cleared by reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            l_data_q <= PCL_RST_PORT; // RULE_16
            l_cfg_q  <= PCL_RST_PORT; // RULE_16
            g_data_q <= PCL_RST_PORT; // RULE_16
            g_cfg_q  <= PCL_RST_PORT; // RULE_16
            cntrl_q  <= PCL_RST_CNTRL;
        end else if (reg_wr) begin
            if (wr_hit(reg_addr, PCL_ADDR_L_DATA)) l_data_q <= reg_wdata;
            if (wr_hit(reg_addr, PCL_ADDR_L_CFG))  l_cfg_q  <= reg_wdata;
            if (wr_hit(reg_addr, PCL_ADDR_G_DATA)) g_data_q <= reg_wdata;
            if (wr_hit(reg_addr, PCL_ADDR_G_CFG))  g_cfg_q  <= reg_wdata;
            if (wr_hit(reg_addr, PCL_ADDR_CNTRL))  cntrl_q  <= reg_wdata;
        end
    end

    // Output-only port, preset high under reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            d_data_q  <= PCL_RST_D; // RULE_15
            d_pin_out <= PCL_RST_D; // RULE_15
        end else begin
            if (reg_wr && wr_hit(reg_addr, PCL_ADDR_D_DATA)) d_data_q <= reg_wdata[3:0];
            d_pin_out <= d_data_q;
        end
    end

    // Two-stage synchronisers for all pin inputs
    // No reset here: the stages track the pins through reset, so the first
    // level seen after release is real and no false edge follows reset
    always_ff @(posedge mclk) begin
        l_s1_q     <= l_pin_in;    // RULE_18
        l_s2_q     <= l_s1_q;      // RULE_18
        g_s1_q     <= g_pin_in;    // RULE_18
        g_s2_q     <= g_s1_q;      // RULE_18
        i_s1_q     <= i_pin_in;    // RULE_14
        i_s2_q     <= i_s1_q;      // RULE_14
        fault_s1_q <= fault_n;
        fault_s2_q <= fault_s1_q;
    end

    // Pin 7 history for the rising-edge detect, free of reset as well
    always_ff @(posedge mclk) begin
        g7_prev_q <= g_s2_q[PCL_G_OSC_BIT];
    end

    // Oscillator option strap, caught after reset
    // Reset value picks RC so pin 7 never drives in the cycle after release
    always_ff @(posedge mclk) begin
        if (reset) begin
            rc_q <= 1'h1;
        end else begin
            rc_q <= rc_osc_option;
        end
    end

    // Read mux, data one cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            PCL_ADDR_L_DATA: rdata_d = l_data_q;
            PCL_ADDR_L_CFG:  rdata_d = l_cfg_q;
            PCL_ADDR_L_PIN:  rdata_d = {l_s2_q, PCL_L_LOW_ONES}; // RULE_03
            PCL_ADDR_G_DATA: rdata_d = {2'h0, g_data_q[5:0]};    // RULE_05
            PCL_ADDR_G_CFG:  rdata_d = g_cfg_q;
            PCL_ADDR_G_PIN:  rdata_d = g_s2_q;                   // RULE_02
            PCL_ADDR_I_PIN:  rdata_d = i_s2_q;                   // RULE_14
            PCL_ADDR_D_DATA: rdata_d = {4'h0, d_data_q};
            PCL_ADDR_CNTRL:  rdata_d = cntrl_q;
            default:         rdata_d = 8'h00;
        endcase
    end

    // Registered read data
    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end

    // Four-pin port drivers, upper nibble only
    always_ff @(posedge mclk) begin
        if (reset) begin
            l_pin_out <= 4'h0;
            l_pin_oe  <= 4'h0;
            l_pull_en <= 4'h0;
        end else begin
            l_pin_out <= l_data_q[7:4];                  // RULE_01
            l_pin_oe  <= l_cfg_q[7:4];                   // RULE_01
            l_pull_en <= ~l_cfg_q[7:4] & l_data_q[7:4];  // RULE_01
        end
    end

    // Eight-bit port drivers with dedicated and alternate pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            g_pin_out <= 8'h00;
            g_pin_oe  <= 8'h00;
            g_pull_en <= 8'h00;
        end else begin
            g_pin_out <= {1'h0, 1'h0, g_data_q[5:0]};                     // RULE_01
            g_pin_oe  <= {1'h0, 1'h0, g_cfg_q[5:2], 1'h0, g_cfg_q[0]};   // RULE_01
            g_pull_en <= {1'h0, 1'h0, ~g_cfg_q[5:0] & g_data_q[5:0]};    // RULE_01
            g_pull_en[PCL_G_FAULT_BIT] <= 1'h0;
            // Fault pin: drives low on fault, hi-z otherwise
            g_pin_out[PCL_G_FAULT_BIT] <= 1'h0;                  // RULE_12
            g_pin_oe[PCL_G_FAULT_BIT]  <= ~fault_s2_q;           // RULE_12
            // Timer I/O overrides when the timer drives
            if (timer_io_oe) begin
                g_pin_out[3] <= timer_io_out;                    // RULE_13
                g_pin_oe[3]  <= 1'h1;                            // RULE_13
            end
            // Serial select takes pins 5 and 4
            if (cntrl_q[PCL_CNTRL_SEL]) begin
                g_pin_out[5] <= shift_clock_out;                 // RULE_17
                g_pin_out[4] <= serial_data_out;                 // RULE_17
                g_pin_oe[5]  <= 1'h1;                            // RULE_17
                g_pin_oe[4]  <= 1'h1;                            // RULE_17
            end
            // Crystal option: pin 7 carries oscillator output
            if (!rc_q) begin
                g_pin_out[PCL_G_OSC_BIT] <= osc_clock;           // RULE_11
                g_pin_oe[PCL_G_OSC_BIT]  <= 1'h1;                // RULE_11
            end
        end
    end

    // Alternate function inputs to peripherals
    always_ff @(posedge mclk) begin
        if (reset) begin
            multi_input_wakeup <= 4'h0;
            ext_irq_in         <= 1'h0;
            timer_capture_pin  <= 1'h0;
            timer_io_in        <= 1'h0;
            serial_data_in     <= 1'h0;
            shift_clock_in     <= 1'h0;
        end else begin
            multi_input_wakeup <= l_s2_q;                        // RULE_04
            ext_irq_in         <= g_s2_q[0];                     // RULE_13
            timer_capture_pin  <= g_s2_q[2];                     // RULE_13
            timer_io_in        <= g_s2_q[3];                     // RULE_13
            serial_data_in     <= g_s2_q[PCL_G_SIN_BIT];         // RULE_13
            shift_clock_in     <= g_s2_q[5];                     // RULE_13
        end
    end

    // Mode controls from special bits
    always_ff @(posedge mclk) begin
        if (reset) begin
            deep_stop_req        <= 1'h0;
            light_sleep_req      <= 1'h0;
            shift_alt_phase      <= 1'h0;
            restart_delay_enable <= 1'h0;
            rc_wake              <= 1'h0;
        end else begin
            deep_stop_req   <= reg_wr && wr_hit(reg_addr, PCL_ADDR_G_DATA)
                               && reg_wdata[7];                              // RULE_06
            light_sleep_req <= reg_wr && wr_hit(reg_addr, PCL_ADDR_G_DATA)
                               && reg_wdata[6];                              // RULE_07
            shift_alt_phase <= g_cfg_q[6];                                   // RULE_08
            restart_delay_enable <= g_cfg_q[7] && rc_q;                      // RULE_09
            rc_wake   <= rc_q && g_s2_q[PCL_G_OSC_BIT] && !g7_prev_q;        // RULE_10
        end
    end

    // Checks beside the logic
    property p_deep_stop;
        @(posedge mclk) disable iff (reset)
        reg_wr && reg_addr == PCL_ADDR_G_DATA && reg_wdata[7] |=> deep_stop_req;
    endproperty
    a_deep_stop: assert property (p_deep_stop) else $error("deep stop missed"); // RULE_06
    property p_sleep;
        @(posedge mclk) disable iff (reset)
        reg_wr && reg_addr == PCL_ADDR_G_DATA && reg_wdata[6] |=> light_sleep_req;
    endproperty
    a_sleep: assert property (p_sleep) else $error("light sleep missed"); // RULE_07
    property p_g_rd_zero;
        @(posedge mclk) disable iff (reset)
        reg_rd && reg_addr == PCL_ADDR_G_DATA |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_g_rd_zero: assert property (p_g_rd_zero) else $error("g bits 6,7 not zero"); // RULE_05
    property p_l_ones;
        @(posedge mclk) disable iff (reset)
        reg_rd && reg_addr == PCL_ADDR_L_PIN |=> reg_rdata[3:0] == 4'hf;
    endproperty
    a_l_ones: assert property (p_l_ones) else $error("l low bits not ones"); // RULE_03
    property p_d_reset;
        @(posedge mclk) reset |=> d_pin_out == 4'hf;
    endproperty
    a_d_reset: assert property (p_d_reset) else $error("d not high in reset"); // RULE_15
    property p_l_pull;
        @(posedge mclk) disable iff (reset)
        ##1 !l_cfg_q[4] && l_data_q[4] && $stable(l_cfg_q) && $stable(l_data_q)
        |=> l_pull_en[0] && !l_pin_oe[0];
    endproperty
    a_l_pull: assert property (p_l_pull) else $error("pull-up not set"); // RULE_01
    property p_sync;
        @(posedge mclk) disable iff (reset)
        ##3 reg_rd && reg_addr == PCL_ADDR_I_PIN && $stable(i_pin_in) && $past(i_pin_in) == $past(i_pin_in, 2)
        |=> reg_rdata == $past(i_pin_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pin read not synced"); // RULE_18
    property p_fault;
        @(posedge mclk) disable iff (reset)
        g_pin_oe[1] |-> !g_pin_out[1];
    endproperty
    a_fault: assert property (p_fault) else $error("fault pin drove high"); // RULE_12
    property p_delay;
        @(posedge mclk) disable iff (reset)
        restart_delay_enable |-> $past(rc_q);
    endproperty
    a_delay: assert property (p_delay) else $error("delay without rc"); // RULE_09
    // Serial select drives both serial pins from the shift interface
    property p_serial_oe;
        @(posedge mclk) disable iff (reset)
        cntrl_q[PCL_CNTRL_SEL] |=> g_pin_oe[5:4] == 2'h3
            && g_pin_out[5] == $past(shift_clock_out) && g_pin_out[4] == $past(serial_data_out);
    endproperty
    a_serial_oe: assert property (p_serial_oe) else $error("serial pins not routed"); // RULE_17
    // Crystal option drives the oscillator level on pin 7
    property p_crystal_drive;
        @(posedge mclk) disable iff (reset)
        !rc_q |=> g_pin_oe[PCL_G_OSC_BIT] && g_pin_out[PCL_G_OSC_BIT] == $past(osc_clock);
    endproperty
    a_crystal_drive: assert property (p_crystal_drive) else $error("osc pin not driven"); // RULE_11
    // RC option leaves pin 7 as an input
    property p_pin7_input;
        @(posedge mclk) disable iff (reset)
        rc_q |=> !g_pin_oe[PCL_G_OSC_BIT];
    endproperty
    a_pin7_input: assert property (p_pin7_input) else $error("pin 7 driven in rc mode"); // RULE_10
    // Read data is zero outside the cycle after a read strobe
    property p_rdata_idle;
        @(posedge mclk) disable iff (reset)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle"); // RULE_02
    // Fault pin enable follows the fault input three cycles later
    property p_fault_follow;
        @(posedge mclk) disable iff (reset)
        ##2 1'b1 |=> g_pin_oe[PCL_G_FAULT_BIT] == !$past(fault_n, 3);
    endproperty
    a_fault_follow: assert property (p_fault_follow) else $error("fault pin late"); // RULE_12
    c_stop: cover property (@(posedge mclk) deep_stop_req);
    c_sleep: cover property (@(posedge mclk) light_sleep_req);
    c_wake: cover property (@(posedge mclk) rc_wake);
    c_serial: cover property (@(posedge mclk) cntrl_q[PCL_CNTRL_SEL] && g_pin_oe[4]);

endmodule : pcl_port

// ### tb/pcl_pin_model.sv
// Board model: resolves port pin levels from design drive, pull-ups and board sources
`timescale 1ns/1ps
module pcl_pin_model #(
    parameter int W = 8                // Pin count
) (
    // Clock
    input  wire logic         mclk,
    // Design side of the pins
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] pull_en,
    // Board sources
    input  wire logic [W-1:0] board_val,
    input  wire logic [W-1:0] board_en,
    // Resolved levels back to the design
    output logic      [W-1:0] pin_in
);
    logic [W-1:0] float_q = '0;        // Level of a floating pin
    // Floating pins wander every cycle so a stale level never reads as valid
    always_ff @(posedge mclk) begin
        float_q <= ~pin_in;
    end
    // Design drive wins, then board drive, then weak pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (board_en[i]) begin
                pin_in[i] = board_val[i];
            end else if (pull_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_q[i];
            end
        end
    end
endmodule : pcl_pin_model

// ### tb/pcl_port_tb_top.sv
// Testbench: register accesses and pin scenarios for the port pin logic
`timescale 1ns/1ps
module pcl_port_tb_top;
    import pcl_pkg::*;
    // Clock, reset and register port
    logic       mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
    // Straps and peripheral sources
    logic rc_osc_option = 1'b1, osc_clock = 1'b1, fault_n = 1'b1;
    logic shift_clock_out = 1'b0, serial_data_out = 1'b0, timer_io_out = 1'b0, timer_io_oe = 1'b0;
    // Pins and peripheral outputs
    logic [3:0] l_pin_in, l_pin_out, l_pin_oe, l_pull_en, d_pin_out, multi_input_wakeup;
    logic [7:0] g_pin_in, g_pin_out, g_pin_oe, g_pull_en, i_pin_in = 8'h00;
    logic ext_irq_in, timer_capture_pin, timer_io_in, serial_data_in, shift_clock_in;
    logic deep_stop_req, light_sleep_req, shift_alt_phase, restart_delay_enable, rc_wake;
    // Board drive of the bidirectional pins
    logic [7:0] g_bval = 8'h00, g_ben = 8'hff;
    logic [3:0] l_bval = 4'h0, l_ben = 4'hf;
    int err_count = 0, n_compared = 0, cycles = 0, wake_cnt = 0;

    pcl_port pcl_port_i (
        .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rc_osc_option, .osc_clock, .fault_n, .shift_clock_out, .serial_data_out,
        .timer_io_out, .timer_io_oe, .l_pin_in, .l_pin_out, .l_pin_oe, .l_pull_en,
        .g_pin_in, .g_pin_out, .g_pin_oe, .g_pull_en, .i_pin_in, .d_pin_out,
        .multi_input_wakeup, .ext_irq_in, .timer_capture_pin, .timer_io_in,
        .serial_data_in, .shift_clock_in, .deep_stop_req, .light_sleep_req,
        .shift_alt_phase, .restart_delay_enable, .rc_wake);
    pcl_pin_model #(.W(8)) pcl_pin_model_i (.mclk, .pin_out(g_pin_out), .pin_oe(g_pin_oe),
        .pull_en(g_pull_en), .board_val(g_bval), .board_en(g_ben), .pin_in(g_pin_in));
    pcl_pin_model #(.W(4)) pcl_pin_model_l_i (.mclk, .pin_out(l_pin_out), .pin_oe(l_pin_oe),
        .pull_en(l_pull_en), .board_val(l_bval), .board_en(l_ben), .pin_in(l_pin_in));

    // Clock at 200 MHz
    always #2.5 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end
    // Count wake pulses
    always @(posedge mclk) begin
        if (rc_wake === 1'b1) wake_cnt++;
    end

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle read strobe, data taken in the following cycle only
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rdc
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    task automatic board(input logic [7:0] g, input logic [3:0] l, input logic [7:0] i);
        @(posedge mclk);
        g_bval   <= g;
        g_ben    <= 8'hff;
        l_bval   <= l;
        i_pin_in <= i;
    endtask : board

    initial begin
        settle(10);
        check(d_pin_out, 4'hf);
        check(g_pin_oe, 8'h00);
        @(posedge mclk);
        reset <= 1'b0;
        g_ben <= 8'hfe;
        rdc(PCL_ADDR_G_CFG, PCL_RST_PORT);
        rdc(PCL_ADDR_L_DATA, PCL_RST_PORT);
        // All four set-ups on G0 and L4, board released on G0
        for (int m = 0; m < 4; m++) begin
            wr(PCL_ADDR_G_CFG, {7'h00, m[1]});
            wr(PCL_ADDR_G_DATA, {7'h00, m[0]});
            wr(PCL_ADDR_L_CFG, {3'h0, m[1], 4'h0});
            wr(PCL_ADDR_L_DATA, {3'h0, m[0], 4'h0});
            settle(4);
            check(g_pin_oe[0], m[1]);
            check(g_pull_en[0], m == 1);
            check(l_pin_oe[0], m[1]);
            check(l_pull_en[0], m == 1);
            check({g_pin_out[0], l_pin_out[0]}, {2{m[0]}});
            if (m != 0) rdc(PCL_ADDR_G_PIN, {7'h00, m[0]});
        end
        wr(PCL_ADDR_G_CFG, 8'h00);
        wr(PCL_ADDR_L_CFG, 8'h00);
        // Pin levels and alternate inputs
        board(8'h4d, 4'h5, 8'h3c);
        settle(4);
        rdc(PCL_ADDR_G_PIN, 8'h4d);
        rdc(PCL_ADDR_I_PIN, 8'h3c);
        check(multi_input_wakeup, 4'h5);
        check({ext_irq_in, timer_capture_pin, timer_io_in, serial_data_in}, 4'hf);
        check(shift_clock_in, 1'b0);
        wr(PCL_ADDR_L_DATA, 8'h0a);
        rdc(PCL_ADDR_L_DATA, 8'h0a);
        rdc(PCL_ADDR_L_PIN, 8'h5f);
        rdc(8'h00, 8'h00);
        // Sleep mode requests
        wr(PCL_ADDR_G_DATA, 8'h80);
        #1;
        check({deep_stop_req, light_sleep_req}, 2'b10);
        settle(1);
        check({deep_stop_req, light_sleep_req}, 2'b00);
        rdc(PCL_ADDR_G_DATA, 8'h00);
        wr(PCL_ADDR_G_DATA, 8'h40);
        #1;
        check({deep_stop_req, light_sleep_req}, 2'b01);
        // Special configuration bits and oscillator pin
        wr(PCL_ADDR_G_CFG, 8'hc0);
        settle(2);
        check(shift_alt_phase, 1'b1);
        check(restart_delay_enable, 1'b1);
        @(posedge mclk);
        rc_osc_option <= 1'b0;
        settle(3);
        check(restart_delay_enable, 1'b0);
        check(g_pin_oe[7:6], 2'b10);
        check(g_pin_out[7], osc_clock);
        @(posedge mclk);
        rc_osc_option <= 1'b1;
        board(8'h00, 4'h0, 8'h00);
        settle(4);
        check(g_pin_oe[7], 1'b0);
        wake_cnt = 0;
        board(8'h80, 4'h0, 8'h00);
        settle(6);
        check(wake_cnt[7:0], 8'h01);
        // Fault output pin
        @(posedge mclk);
        fault_n <= 1'b0;
        settle(4);
        check({g_pin_oe[1], g_pin_out[1]}, 2'b10);
        @(posedge mclk);
        fault_n <= 1'b1;
        wr(PCL_ADDR_G_CFG, 8'h02);
        wr(PCL_ADDR_G_DATA, 8'h02);
        settle(4);
        check(g_pin_oe[1], 1'b0);
        check(g_pin_oe[5:4], 2'b00);
        // Serial and timer routing
        @(posedge mclk);
        shift_clock_out <= 1'b1;
        timer_io_oe     <= 1'b1;
        timer_io_out    <= 1'b1;
        wr(PCL_ADDR_CNTRL, 8'h08);
        settle(3);
        check(g_pin_oe[5:3], 3'b111);
        check(g_pin_out[5:3], 3'b101);
        // Output-only port, then a reset in mid-run
        wr(PCL_ADDR_D_DATA, 8'h05);
        settle(2);
        check(d_pin_out, 4'h5);
        @(posedge mclk);
        reset <= 1'b1;
        settle(2);
        check(d_pin_out, 4'hf);
        check(g_pin_oe, 8'h00);
        @(posedge mclk);
        reset <= 1'b0;
        rdc(PCL_ADDR_G_CFG, PCL_RST_PORT);
        stop_test();
    end
endmodule : pcl_port_tb_top
